// ==== design/xmii_fifo.sv ====
`timescale 1ns/1ps
module xmii_fifo #(
  parameter int W = 6,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_q];

  always_comb begin
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Storage needs no reset; flags guard every read
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_q + AW'(push);
      rd_q <= rd_q + AW'(pop);
      cnt_q <= cnt_d;
    end
  end

  // Flags from the next count so both stay registered yet exact
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      in_ready <= cnt_d != (AW+1)'(DEPTH);
      out_valid <= cnt_d != '0;
    end
  end
endmodule

// ==== design/xmii_pkg.sv ====
// Contract
// - In MII and RGMII modes each receive nibble goes out on all four receive data lines, changing at the receive clock rising edge.
// - In RMII mode receive data uses only the two low data lines; the two upper lines are unused, save line 3 when RMII master is strapped.
// - With RMII master strapped, the reference clock is driven out on receive data line 3 to feed the MAC.
// - In MII and RGMII modes a receive clock is driven out; in RMII mode it is unused.
// - Receive error goes high on an error symbol inside a packet, on the receive clock edge (MII) or reference edge (RMII), unused in RGMII.
// - On a receive error the forwarded data is corrupted so the MAC need not watch receive error.
// - In MII mode receive data valid is high exactly while valid data is on the four data lines.
// - In RMII mode one combined carrier-sense/data-valid signal is driven; data is on the two low lines while it is high.
// - In RGMII mode valid and error share one control line: valid at the clock rising edge, error at the falling edge; the code sends valid XOR error there.
// - In MII mode a transmit clock is driven out with constant phase to the reference clock; unused in RMII.
package xmii_pkg;
  localparam logic [11:0] CTRL_IDX = 12'h017;
  localparam logic [11:0] STATUS_IDX = 12'h018;
  localparam logic [11:0] CTRL_ADDR = {CTRL_IDX[9:0], 2'b00};
  localparam logic [11:0] STATUS_ADDR = {STATUS_IDX[9:0], 2'b00};
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam int MODE_LSB = 0;
  localparam int MASTER_BIT = 2;
  localparam int SYNC_RGMII_BIT = 3;
  localparam int ST_RX_ACT = 0;
  localparam int ST_TX_ACT = 1;
  localparam int ST_EMPTY = 2;
  localparam int ST_FULL = 3;
  localparam logic [3:0] CORRUPT_NIB = 4'hE;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [1:0] {
    MODE_MII = 2'b00,
    MODE_RMII = 2'b01,
    MODE_RGMII = 2'b10
  } mode_t;

  typedef enum logic {
    RX_IDLE = 1'b0,
    RX_SEND = 1'b1
  } rx_state_t;

  typedef struct packed {
    logic last;
    logic err;
    logic [3:0] data;
  } rx_sym_t;

  typedef struct packed {
    logic er;
    logic half;
    logic [3:0] data;
  } tx_sym_t;

  typedef struct packed {
    logic clk;
    logic en;
    logic er;
    logic [3:0] d;
  } tx_pins_t;

  function automatic mode_t mode_of(input logic [15:0] c);
    case (c[MODE_LSB+:2])
      2'b00: mode_of = MODE_MII;
      2'b01: mode_of = MODE_RMII;
      2'b10: mode_of = MODE_RGMII;
      default: mode_of = MODE_MII;
    endcase
  endfunction
endpackage

// ==== design/xmii_port.sv ====
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
module xmii_port #(
  parameter int DEPTH = xmii_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Reference clock pin
  input wire logic ref_clk,
  // Receive symbols from the line decoder
  input wire logic rx_sym_valid,
  input wire xmii_pkg::rx_sym_t rx_sym,
  output logic rx_sym_ready,
  // Receive pins to the MAC
  output logic rx_clk,
  output logic [3:0] rx_d,
  output logic rx_ctrl,
  output logic rx_er,
  // Transmit pins from the MAC
  input wire logic tx_clk_in,
  output logic tx_clk_out,
  output logic tx_clk_oe,
  input wire logic tx_en,
  input wire logic [3:0] tx_d,
  input wire logic tx_er,
  // Transmit symbols to the line encoder
  output logic tx_sym_valid,
  output xmii_pkg::tx_sym_t tx_sym
);
  logic [15:0] ctrl_q;
  xmii_pkg::mode_t mode;
  logic rmii;
  logic rgmii;
  logic master;

  assign mode = xmii_pkg::mode_of(ctrl_q);
  assign rmii = mode == xmii_pkg::MODE_RMII;
  assign rgmii = mode == xmii_pkg::MODE_RGMII;
  assign master = rmii && ctrl_q[xmii_pkg::MASTER_BIT];

  // Pin synchronisers
  logic ref_m_q;
  logic ref_s_q;
  logic ref_d_q;
  logic ref_rise;
  xmii_pkg::tx_pins_t txp_m_q;
  xmii_pkg::tx_pins_t txp_s_q;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ref_m_q <= 1'b0;
      ref_s_q <= 1'b0;
      ref_d_q <= 1'b0;
      txp_m_q <= '0;
      txp_s_q <= '0;
    end else begin
      ref_m_q <= ref_clk;
      ref_s_q <= ref_m_q;
      ref_d_q <= ref_s_q;
      txp_m_q <= '{clk: tx_clk_in, en: tx_en, er: tx_er, d: tx_d};
      txp_s_q <= txp_m_q;
    end
  end

  assign ref_rise = ref_s_q && !ref_d_q;

  // Bus slave
  logic acc;
  logic wr_pend_q;
  logic [11:0] waddr_q;
  logic [15:0] ctrl_fwd;
  logic [3:0] status;
  logic fifo_valid;
  xmii_pkg::rx_sym_t head;
  logic pop;
  xmii_pkg::rx_state_t st_q;
  xmii_pkg::rx_state_t st_d;

  assign acc = hsel && hready && htrans[1];
  // Read right behind a write sees the written value
  assign ctrl_fwd = (wr_pend_q && waddr_q == xmii_pkg::CTRL_ADDR) ? hwdata[15:0] : ctrl_q;
  assign status = {!rx_sym_ready, !fifo_valid, txp_s_q.en, st_q == xmii_pkg::RX_SEND};

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      wr_pend_q <= 1'b0;
      waddr_q <= '0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= acc && hwrite;
      waddr_q <= haddr[11:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ctrl_q <= xmii_pkg::CTRL_RESET;
    end else if (wr_pend_q && waddr_q == xmii_pkg::CTRL_ADDR) begin
      ctrl_q <= hwdata[15:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      hrdata <= '0;
    end else if (acc && !hwrite) begin
      if (haddr[11:0] == xmii_pkg::CTRL_ADDR) begin
        hrdata <= {16'h0000, ctrl_fwd};
      end else if (haddr[11:0] == xmii_pkg::STATUS_ADDR) begin
        hrdata <= {28'h0000000, status};
      end else begin
        hrdata <= '0;
      end
    end
  end

  // Receive buffer
  xmii_fifo #(.W($bits(xmii_pkg::rx_sym_t)), .DEPTH(DEPTH)) u_fifo (
    .clock(clock),
    .rst_b(rst_b),
    .in_valid(rx_sym_valid),
    .in_data(rx_sym),
    .in_ready(rx_sym_ready),
    .out_valid(fifo_valid),
    .out_data(head),
    .out_ready(pop)
  );

  // Receive sequencer, advanced on reference rising edges
  logic hi_q;
  logic hi_d;
  logic err_q;
  logic err_d;
  logic last_q;
  logic last_d;
  logic [3:0] nib_q;
  logic [3:0] nib_d;
  logic [3:0] pres_d;
  logic dv_d;

  always_comb begin
    st_d = st_q;
    hi_d = hi_q;
    err_d = err_q;
    last_d = last_q;
    nib_d = nib_q;
    pop = 1'b0;
    if (ref_rise) begin
      if (rmii && st_q == xmii_pkg::RX_SEND && !hi_q) begin
        hi_d = 1'b1;
      end else if (fifo_valid && !(st_q == xmii_pkg::RX_SEND && last_q)) begin
        pop = 1'b1;
        st_d = xmii_pkg::RX_SEND;
        hi_d = 1'b0;
        err_d = head.err;
        last_d = head.last;
        nib_d = head.err ? xmii_pkg::CORRUPT_NIB : head.data;
      end else begin
        // Underrun or end of frame: drop valid for at least one edge
        st_d = xmii_pkg::RX_IDLE;
        hi_d = 1'b0;
        err_d = 1'b0;
        last_d = 1'b0;
        nib_d = 4'h0;
      end
    end
    dv_d = st_d == xmii_pkg::RX_SEND;
    pres_d = rmii ? {2'b00, hi_d ? nib_d[3:2] : nib_d[1:0]} : nib_d;
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      st_q <= xmii_pkg::RX_IDLE;
      hi_q <= 1'b0;
      err_q <= 1'b0;
      last_q <= 1'b0;
      nib_q <= 4'h0;
    end else begin
      st_q <= st_d;
      hi_q <= hi_d;
      err_q <= err_d;
      last_q <= last_d;
      nib_q <= nib_d;
    end
  end

  // Receive pins
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rx_d <= 4'h0;
    end else begin
      if (ref_rise) begin
        rx_d <= pres_d;
      end
      if (master) begin
        rx_d[3] <= ref_s_q;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rx_er <= 1'b0;
    end else if (ref_rise) begin
      rx_er <= err_d && !rgmii;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rx_ctrl <= 1'b0;
    end else if (rgmii) begin
      rx_ctrl <= ref_s_q ? dv_d : dv_d ^ err_d;
    end else begin
      rx_ctrl <= dv_d;
    end
  end

  // Clock outputs track the synchronised reference
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rx_clk <= 1'b0;
      tx_clk_out <= 1'b0;
      tx_clk_oe <= 1'b0;
    end else begin
      rx_clk <= !rmii && ref_s_q;
      tx_clk_out <= mode == xmii_pkg::MODE_MII && ref_s_q;
      tx_clk_oe <= mode == xmii_pkg::MODE_MII;
    end
  end

  // Transmit capture; the MAC clock only counts in RGMII
  logic tclk;
  logic tclk_q;
  logic t_rise;
  logic t_fall;
  logic tx_hi_q;
  logic [1:0] low_q;
  logic rg_en_q;
  logic [3:0] rg_d_q;

  assign tclk = rgmii ? txp_s_q.clk : ref_s_q;
  assign t_rise = tclk && !tclk_q;
  assign t_fall = !tclk && tclk_q;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      tclk_q <= 1'b0;
      tx_hi_q <= 1'b0;
      low_q <= 2'b00;
      rg_en_q <= 1'b0;
      rg_d_q <= 4'h0;
      tx_sym_valid <= 1'b0;
      tx_sym <= '0;
    end else begin
      tclk_q <= tclk;
      tx_sym_valid <= 1'b0;
      if (t_rise) begin
        unique case (mode)
          xmii_pkg::MODE_MII: begin
            if (txp_s_q.en) begin
              tx_sym_valid <= 1'b1;
              tx_sym <= '{er: txp_s_q.er, half: 1'b0, data: txp_s_q.d};
            end
          end
          xmii_pkg::MODE_RMII: begin
            if (txp_s_q.en && !tx_hi_q) begin
              low_q <= txp_s_q.d[1:0];
              tx_hi_q <= 1'b1;
            end else if (txp_s_q.en) begin
              tx_sym_valid <= 1'b1;
              tx_sym <= '{er: 1'b0, half: 1'b0, data: {txp_s_q.d[1:0], low_q}};
              tx_hi_q <= 1'b0;
            end else if (tx_hi_q) begin
              // Odd dibit at frame end goes out as a half nibble
              tx_sym_valid <= 1'b1;
              tx_sym <= '{er: 1'b0, half: 1'b1, data: {2'b00, low_q}};
              tx_hi_q <= 1'b0;
            end
          end
          xmii_pkg::MODE_RGMII: begin
            rg_en_q <= txp_s_q.en;
            rg_d_q <= txp_s_q.d;
          end
        endcase
      end
      if (t_fall && rgmii && rg_en_q) begin
        tx_sym_valid <= 1'b1;
        tx_sym <= '{er: txp_s_q.en ^ rg_en_q, half: 1'b0, data: rg_d_q};
      end
    end
  end

  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  mii_data_edge_a: assert property (
    mode != xmii_pkg::MODE_RMII && $stable(mode) && rx_d != $past(rx_d) |-> $rose(rx_clk))
    else $error("receive data changed away from a clock rising edge");

  rmii_upper_idle_a: assert property (
    rmii && !master && $past(rmii) |-> rx_d[3:2] == 2'b00)
    else $error("upper receive lines driven in RMII");

  rmii_ref_out_a: assert property (
    master && $past(master) |-> rx_d[3] == $past(ref_s_q))
    else $error("reference clock not on data line 3");

  rx_clk_quiet_a: assert property (
    rmii && $past(rmii) |-> !rx_clk)
    else $error("receive clock toggles in RMII");

  rx_err_frame_a: assert property (
    rx_er |-> st_q == xmii_pkg::RX_SEND && !rgmii)
    else $error("receive error outside a packet");

  rx_corrupt_a: assert property (
    rx_er && mode == xmii_pkg::MODE_MII |-> rx_d == xmii_pkg::CORRUPT_NIB)
    else $error("errored nibble forwarded uncorrupted");

  mii_valid_data_a: assert property (
    mode == xmii_pkg::MODE_MII && $stable(mode) && !rx_ctrl |-> rx_d == 4'h0)
    else $error("data presented without receive valid");

  rmii_crs_data_a: assert property (
    rmii && $stable(mode) && !rx_ctrl |-> rx_d[1:0] == 2'b00)
    else $error("RMII data without carrier sense");

  rgmii_ctrl_mux_a: assert property (
    rgmii && $past(rgmii) |-> rx_ctrl == (rx_clk ? st_q : (st_q ^ err_q)))
    else $error("RGMII receive control mux wrong");

  tx_clk_drive_a: assert property (
    mode == xmii_pkg::MODE_MII ##1 mode == xmii_pkg::MODE_MII
      |-> tx_clk_oe && tx_clk_out == $past(ref_s_q))
    else $error("MII transmit clock not driven from reference");
endmodule

// ==== verif/mac_model.sv ====
`timescale 1ns/1ps
module mac_model (
  // Clocks seen by the MAC
  input wire logic ref_clk,
  input wire logic tx_clk_pin,
  // MAC transmit pins
  output logic mac_clk,
  output logic tx_en,
  output logic tx_er,
  output logic [3:0] tx_d
);
  initial begin
    mac_clk = 1'b0;
    tx_en = 1'b0;
    tx_er = 1'b0;
    tx_d = 4'h0;
  end

  // In MII and RMII setup is met by driving on the falling edge ahead of each rising edge; RGMII drives 50 ns before its own rising edge
  task automatic send(input logic [1:0] m, input logic [31:0] w, input int n, input int e);
    // Own clock frames start off the system clock edges
    if (m == 2'b10)
      #7;
    for (int i = 0; i < n; i++) begin
      if (m == 2'b00) begin
        @(negedge tx_clk_pin);
        #1;
        tx_en = 1'b1;
        tx_d = w[4*i+:4];
        tx_er = (i == e);
      end else if (m == 2'b01) begin
        for (int h = 0; h < 2; h++) begin
          @(negedge ref_clk);
          tx_en = 1'b1;
          tx_d = {2'b00, w[4*i+2*h+:2]};
        end
      end else begin
        tx_en = 1'b1;
        tx_d = w[4*i+:4];
        #50 mac_clk = 1'b1;
        #50 tx_en = (i != e);
        #50 mac_clk = 1'b0;
        #50;
      end
    end
    // Link clock stands still between frames in RGMII
    if (m == 2'b00) begin
      @(negedge tx_clk_pin);
      #1;
    end else if (m == 2'b01) begin
      @(negedge ref_clk);
    end
    tx_en = 1'b0;
    tx_er = 1'b0;
    tx_d = 4'h0;
  endtask
endmodule

// ==== verif/test_xmii_port.sv ====
`timescale 1ns/1ps
module test_xmii_port;
  logic clock, rst_b, hsel, hwrite, rx_sym_valid, ref_clk, prev_c, full_seen;
  logic [31:0] haddr, hwdata, hrdata, r, w;
  logic [1:0] htrans, md;
  logic [2:0] hsize;
  logic hreadyout, hresp, rx_sym_ready, rx_clk, rx_ctrl, rx_er;
  logic [3:0] rx_d, tx_d;
  logic tx_clk_out, tx_clk_oe, tx_en, tx_er, mac_clk, tx_clk_pin, tx_sym_valid;
  xmii_pkg::rx_sym_t rx_sym;
  xmii_pkg::tx_sym_t tx_sym;
  logic [5:0] rxq[$];
  logic [5:0] txq[$];
  int n_errors = 0;
  int total_checks = 0;

  // Shared TX_CLK wire: the device drives it only in MII
  assign tx_clk_pin = tx_clk_oe ? tx_clk_out : mac_clk;

  xmii_port i_xmii_port (.clock, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .ref_clk, .rx_sym_valid, .rx_sym,
    .rx_sym_ready, .rx_clk, .rx_d, .rx_ctrl, .rx_er, .tx_clk_in(tx_clk_pin), .tx_clk_out,
    .tx_clk_oe, .tx_en, .tx_d, .tx_er, .tx_sym_valid, .tx_sym);
  mac_model i_mac_model (.ref_clk, .tx_clk_pin, .mac_clk, .tx_en, .tx_er, .tx_d);

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // Unrelated phase to the system clock
  initial begin
    ref_clk = 1'b0;
    #37;
    forever #100 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Select stays high between transfers; htrans alone marks each request
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    do begin
      @(posedge clock);
    end while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do begin
      @(posedge clock);
    end while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic setmode(input logic [1:0] m, input logic mst);
    ahb(1'b1, {20'h0, xmii_pkg::CTRL_ADDR}, {29'h0, mst, m});
    md = m;
    repeat (40) @(posedge clock);
  endtask

  // Receive pins sampled once settled, on the edge that carries each unit
  always @(negedge clock) begin
    if (rst_b && rx_ctrl && !prev_c && (md == 2'b01 ? rx_d[3] : rx_clk)) begin
      if (rxq.size() == 0)
        chk(32'h1, 32'h0);
      else
        chk({rx_er, rx_d & (md == 2'b01 ? 4'h3 : 4'hF)}, rxq.pop_front());
    end
    prev_c <= (md == 2'b01) ? rx_d[3] : rx_clk;
    if (tx_sym_valid === 1'b1) begin
      if (txq.size() == 0)
        chk(32'h1, 32'h0);
      else
        chk(tx_sym, txq.pop_front());
    end
  end

  task automatic drain;
    int k;
    k = 0;
    while ((rxq.size() + txq.size()) > 0 && k < 3000) begin
      @(posedge clock);
      k++;
    end
    repeat (40) @(posedge clock);
    chk(rxq.size() + txq.size(), 0);
    chk(rx_ctrl, 1'b0);
  endtask

  task automatic rx_frame(input int n, input int e);
    logic [3:0] nib, dd;
    logic ex;
    for (int i = 0; i < n; i++) begin
      nib = 4'($urandom);
      ex = (md != 2'b10) && (i == e);
      dd = (i == e) ? xmii_pkg::CORRUPT_NIB : nib;
      if (md == 2'b01) begin
        rxq.push_back({1'b0, ex, 2'b00, dd[1:0]});
        rxq.push_back({1'b0, ex, 2'b00, dd[3:2]});
      end else
        rxq.push_back({1'b0, ex, dd});
      rx_sym_valid <= 1'b1;
      rx_sym <= {i == n - 1, i == e, nib};
      do begin
        @(posedge clock);
        if (rx_sym_ready === 1'b0)
          full_seen = 1'b1;
      end while (rx_sym_ready !== 1'b1);
    end
    rx_sym_valid <= 1'b0;
    drain();
  endtask

  task automatic print_verdict;
    $display("Checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #400000;
    n_errors++;
    print_verdict();
  end

  initial begin
    rst_b = 1'b0;
    {hsel, hwrite, rx_sym_valid, prev_c, full_seen} = 5'h00;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'b00;
    hsize = 3'b010;
    rx_sym = 6'h00;
    md = 2'b00;
    void'($urandom(88));
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    ahb(1'b0, {20'h0, xmii_pkg::CTRL_ADDR}, 32'h0);
    chk(r, {16'h0, xmii_pkg::CTRL_RESET});
    ahb(1'b1, {20'h0, xmii_pkg::CTRL_ADDR}, 32'hA5A5_000E);
    ahb(1'b0, {20'h0, xmii_pkg::CTRL_ADDR}, 32'h0);
    chk(r, 32'h0000_000E);
    ahb(1'b1, 32'h0000_0100, 32'hFFFF_FFFF);
    ahb(1'b0, 32'h0000_0100, 32'h0);
    chk(r, 32'h0);
    chk(hresp, 1'b0);
    ahb(1'b0, {20'h0, xmii_pkg::STATUS_ADDR}, 32'h0);
    chk(r, 32'h1 << xmii_pkg::ST_EMPTY);
    $display("Test registers done");
    // MII frame longer than the buffer, so ready must drop
    setmode(2'b00, 1'b0);
    chk(tx_clk_oe, 1'b1);
    rx_frame(12, 3);
    chk(full_seen, 1'b1);
    $display("Test MII receive done");
    setmode(2'b01, 1'b1);
    chk(rx_clk, 1'b0);
    chk(tx_clk_oe, 1'b0);
    rx_frame(5, 2);
    $display("Test RMII receive done");
    setmode(2'b10, 1'b0);
    rx_frame(6, 1);
    $display("Test RGMII receive done");
    for (int m = 0; m < 3; m++) begin
      setmode(2'(m), 1'b0);
      w = $urandom;
      for (int i = 0; i < 6; i++)
        txq.push_back({m != 1 && i == 2, 1'b0, w[4*i+:4]});
      i_mac_model.send(2'(m), w, 6, 2);
      drain();
      $display("Test transmit mode %0d done", m);
    end
    print_verdict();
  end
endmodule
